// >>> core/bcd_readout_handshake.sv
`default_nettype none
module bcd_readout_handshake
  import bcd_readout_pkg::*;
#(
  parameter int unsigned DIGITS = DIGITS_DEF,
  parameter int unsigned SET_CYCLES = SET_CYC,
  parameter int unsigned VALID_CYCLES = VALID_CYC,
  parameter int unsigned RELEASE_CYCLES = RELEASE_CYC,
  parameter int unsigned PERIOD_CYCLES = PERIOD_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic request_in,
  input wire logic hold_in,
  input wire logic [4*DIGITS-1:0] meas_value,
  output logic [4*DIGITS-1:0] bcd_out,
  output logic [4*DIGITS-1:0] bcd_oe,
  output logic valid_out,
  output logic valid_oe
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // request and hold come straight from the reader's wiring and share
  // no clock with us; each passes two flops before anything reads it,
  // and only the second flop of each pair is read by the logic
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_d_ff;
  logic hold_s1_ff;
  logic hold_s2_ff;

  // request pair plus one delay stage for the edge detector; the delay
  // stage resets to the idle level of the pin, so reset makes no false edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_d_ff <= 1'b0;
    end else begin
      req_s1_ff <= request_in;
      req_s2_ff <= req_s1_ff;
      req_d_ff <= req_s2_ff;
    end
  end

  // hold pair; hold only matters during the strobe phase
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_s1_ff <= 1'b0;
      hold_s2_ff <= 1'b0;
    end else begin
      hold_s1_ff <= hold_in;
      hold_s2_ff <= hold_s1_ff;
    end
  end

  // a request is taken on its rising edge only; a reader that leaves the
  // line high gets continuous output, not a new single sample per cycle
  logic req_rise;
  assign req_rise = req_s2_ff & ~req_d_ff;

  ////////////////////////////////////////////////////////////////////////
  // handshake sequencer
  // one timer serves every phase: the set-up delay, the strobe time, the
  // release tail and, while request stays high, the refresh period; it
  // restarts at every phase change and at every refresh
  // latency from the request pin to the strobe is two sync flops, one
  // cycle of edge detect and SET_CYCLES of timer, a few cycles over the
  // nominal set-up time and well inside its tolerance
  hs_state_t state_ff;
  hs_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  // end of a refresh period, only acted on while the strobe is on
  logic period_done;
  assign period_done = (cnt_ff == CNT_W'(PERIOD_CYCLES - 1));

  // next state and timer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + CNT_W'(1);
    case (state_ff)
      // wait for a fresh request edge; the timer is parked at zero
      ST_IDLE: begin
        nxt_cnt = '0;
        if (req_rise) begin
          nxt_state = ST_SET;
        end
      end
      // set-up delay; the snapshot is already latched, so data and strobe
      // leave together at the end of it
      ST_SET: begin
        if (cnt_ff == CNT_W'(SET_CYCLES - 1)) begin
          nxt_state = ST_VALID;
          nxt_cnt = '0;
        end
      end
      // strobe on: refresh each period while request is high; once request
      // is low, end after the strobe time counted from the last update
      ST_VALID: begin
        if (req_s2_ff) begin
          if (period_done) begin
            nxt_cnt = '0;
          end
        end else if (cnt_ff >= CNT_W'(VALID_CYCLES - 1)) begin
          nxt_state = ST_TAIL;
          nxt_cnt = '0;
        end
      end
      // strobe off, data still pulled for the release tail; new request
      // edges are ignored here and in every phase but idle
      ST_TAIL: begin
        if (cnt_ff == CNT_W'(RELEASE_CYCLES - 1)) begin
          nxt_state = ST_IDLE;
          nxt_cnt = '0;
        end
      end
      // an illegal code falls back to idle
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // phase timer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // snapshot latch: loaded as data is set and at each periodic update;
  // a held snapshot is kept whole, so the lines never show a torn word
  logic [4*DIGITS-1:0] snap_ff;
  // first load at the request edge, then once per refresh period; the
  // hold pin only blocks the refresh, never the first load of a sequence
  logic load_first;
  logic load_refresh;
  logic refresh_blocked;
  logic load_snap;
  assign load_first = (state_ff == ST_IDLE) & req_rise;
  assign load_refresh = (state_ff == ST_VALID) & req_s2_ff & period_done;
  assign refresh_blocked = hold_s2_ff & (state_ff == ST_VALID);
  assign load_snap = load_first | (load_refresh & ~refresh_blocked);

  // the latch only ever loads whole words, so a hold that lands on a
  // refresh leaves the old word standing intact
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      snap_ff <= '0;
    end else if (load_snap) begin
      snap_ff <= meas_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // open-collector drivers: a logic one pulls the line low, a zero releases
  // data lines stand from the strobe edge through the release tail; the
  // enables are computed from the next state so they leave a flop in step
  // with the state change, keeping data and strobe aligned to the cycle
  logic data_on;
  logic strobe_on;
  assign data_on = (nxt_state == ST_VALID) | (nxt_state == ST_TAIL);
  assign strobe_on = (nxt_state == ST_VALID);

  // line level driven: always low, so no line is ever pushed high and
  // several indicators may share the wires;
  // the pull-up gives the high level
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bcd_out <= '0;
      valid_out <= 1'b0;
    end else begin
      bcd_out <= '0;
      valid_out <= 1'b0;
    end
  end

  // data enables: a one bit of the snapshot pulls its line, a zero leaves
  // it to the pull-up; released lines read all ones at the reader
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bcd_oe <= '0;
    end else begin
      bcd_oe <= data_on ? snap_ff : '0;
    end
  end

  // strobe enable: on only in the strobe phase, so its fall and the start
  // of the release tail share one clock edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      valid_oe <= 1'b0;
    end else begin
      valid_oe <= strobe_on;
    end
  end

endmodule : bcd_readout_handshake
`default_nettype wire

// >>> core/bcd_readout_pkg.sv
`default_nettype none
package bcd_readout_pkg;
  // timebase and handshake timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SET_TIME_MS = 30;
  localparam int unsigned VALID_TIME_MS = 40;
  localparam int unsigned RELEASE_TIME_MS = 16;
  localparam int unsigned PERIOD_TIME_MS = 64;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SET_CYC = SET_TIME_MS * CYC_PER_MS;
  localparam int unsigned VALID_CYC = VALID_TIME_MS * CYC_PER_MS;
  localparam int unsigned RELEASE_CYC = RELEASE_TIME_MS * CYC_PER_MS;
  localparam int unsigned PERIOD_CYC = PERIOD_TIME_MS * CYC_PER_MS;
  // default measurement width: six bcd digits
  localparam int unsigned DIGITS_DEF = 6;
  localparam int unsigned CNT_W = 32;
  // handshake states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SET = 4'h2,
    ST_VALID = 4'h4,
    ST_TAIL = 4'h8
  } hs_state_t;
endpackage : bcd_readout_pkg
`default_nettype wire

// >>> verif/bcd_reader_model.sv
`default_nettype none
module bcd_reader_model (
  input wire logic mclk,
  input wire logic [23:0] bcd_oe,
  input wire logic valid_oe,
  output logic [23:0] word
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [23:0] lines = ~bcd_oe; // pull-up level
  // sample only while the strobe is active
  always @(posedge mclk) if (valid_oe) word <= ~lines;
endmodule : bcd_reader_model
`default_nettype wire

// >>> verif/bcd_readout_monitor.sv
`default_nettype none
module bcd_readout_monitor #(
  parameter int S = 30,
  parameter int R = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic request_in,
  input wire logic hold_in,
  input wire logic [23:0] bcd_oe,
  input wire logic [23:0] bcd_out,
  input wire logic valid_out,
  input wire logic valid_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HI = S + 4;
  localparam int RH = R + 1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // timing of strobe, data and release
  set_time_a: assert property (
    $rose(request_in) && !valid_oe && bcd_oe == 24'h0 |-> ##[S:HI] $rose(valid_oe))
    else $error("strobe late or early");
  open_drain_a: assert property (bcd_out == 24'h0 && !valid_out)
    else $error("line driven high");
  valid_len_a: assert property ($rose(valid_oe) |=> valid_oe [*8])
    else $error("strobe too short");
  release_tail_a: assert property ($fell(valid_oe) |=> $stable(bcd_oe) [*8])
    else $error("data dropped early");
  release_done_a: assert property ($fell(valid_oe) |-> ##[R:RH] bcd_oe == 24'h0)
    else $error("data not released");
  snap_hold_a: assert property ($rose(valid_oe) |=> $stable(bcd_oe) [*8])
    else $error("snapshot moved");
  hold_keep_a: assert property (
    valid_oe && hold_in && $past(hold_in, 3) |=> $stable(bcd_oe))
    else $error("word changed in hold");
  cover property ($rose(valid_oe));
  cover property (valid_oe && hold_in);
  cover property ($fell(valid_oe));
endmodule : bcd_readout_monitor
`default_nettype wire

// >>> verif/test_bcd_readout_handshake.sv
`default_nettype none
module test_bcd_readout_handshake;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, resetn = 1'b0, request_in = 1'b0, hold_in = 1'b0;
  logic [23:0] meas_value = 24'h0, bcd_out, bcd_oe, word, e;
  logic valid_out, valid_oe;
  int err_total = 0, comparisons = 0, k;
  logic [23:0] q[$];
  initial forever #4 mclk = ~mclk;
  bcd_readout_handshake #(.SET_CYCLES(30), .VALID_CYCLES(40), .RELEASE_CYCLES(16),
    .PERIOD_CYCLES(64)) dut_u (.mclk(mclk), .resetn(resetn), .request_in(request_in),
    .hold_in(hold_in), .meas_value(meas_value), .bcd_out(bcd_out), .bcd_oe(bcd_oe),
    .valid_out(valid_out), .valid_oe(valid_oe));
  bcd_reader_model rd_u (.mclk(mclk), .bcd_oe(bcd_oe), .valid_oe(valid_oe), .word(word));
  function automatic logic [23:0] rnd();
    logic [23:0] v;
    for (int i = 0; i < 6; i++) v[4*i+:4] = 4'($urandom % 10);
    return v;
  endfunction : rnd
  task automatic chk(input string n, input logic [23:0] x, input logic [23:0] s);
    comparisons++;
    if (s !== x) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, x, s);
    end
  endtask : chk
  task automatic until_v(input logic lv);
    k = 0;
    while (valid_oe !== lv && k < 200) begin
      @(negedge mclk);
      k++;
    end
    chk("valid_oe", {23'h0, lv}, {23'h0, valid_oe});
  endtask : until_v
  task automatic summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    #20000;
    err_total++;
    summarize();
  end
  initial begin
    void'($urandom(32'h4a94));
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    // single sampling, twice back to back
    repeat (2) begin
      meas_value = rnd();
      q.push_back(meas_value);
      request_in = 1'b1;
      repeat (3) @(negedge mclk);
      request_in = 1'b0;
      until_v(1'b1);
      meas_value = rnd();
      until_v(1'b0);
      chk("word", q.pop_front(), word);
      k = 0;
      while (bcd_oe !== 24'h0 && k < 100) begin
        @(negedge mclk);
        k++;
      end
      chk("release", 24'h10, 24'(k));
      repeat (20) @(negedge mclk);
      $display("single done");
    end
    // continuous output, then hold
    q.push_back(meas_value);
    request_in = 1'b1;
    until_v(1'b1);
    e = rnd();
    meas_value = e;
    repeat (50) @(negedge mclk);
    chk("kept", q.pop_front(), bcd_oe);
    repeat (20) @(negedge mclk);
    chk("refresh", e, bcd_oe);
    chk("bcd_out", 24'h0, bcd_out);
    chk("valid_out", 24'h0, {23'h0, valid_out});
    hold_in = 1'b1;
    repeat (3) @(negedge mclk);
    meas_value = rnd();
    repeat (70) @(negedge mclk);
    chk("held", e, bcd_oe);
    hold_in = 1'b0;
    request_in = 1'b0;
    until_v(1'b0);
    repeat (20) @(negedge mclk);
    chk("idle", 24'h0, bcd_oe);
    $display("continuous done");
    summarize();
  end
endmodule : test_bcd_readout_handshake
bind bcd_readout_handshake bcd_readout_monitor mon_u (.mclk(mclk), .resetn(resetn),
  .request_in(request_in), .hold_in(hold_in), .bcd_oe(bcd_oe), .bcd_out(bcd_out),
  .valid_out(valid_out), .valid_oe(valid_oe));
`default_nettype wire
